// ===== hdl/fbs_top.sv
`include "fbs_defs.svh"
`default_nettype none
module fbs_top
	import fbs_pkg::*;
#(
	parameter int unsigned  DEB_TICKS  = `FBS_DEB_TICKS,
	parameter bit           LARGE_PART = 1'b1,
	// arbitrary identifier and calibration values
	parameter logic [127:0] UID        = 128'h0123456789ABCDEF0F1E2D3C4B5A6978,
	parameter logic [31:0]  CAL        = 32'h00005A5A
)(
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic [31:0]        reg_rdata,
	input  wire logic          erase_pin_in,
	output logic               erase_pin_out,
	output logic               erase_pin_oe_n,
	input  wire logic          slow_clk_in,
	input  wire logic          test_mode_pin,
	input  wire logic [3:0]    pa_level,
	input  wire logic          prog_command_strobe_n,
	output logic               prog_ready,
	input  wire logic          prog_output_enable_n,
	output logic               prog_data_valid_n,
	input  wire logic [3:0]    prog_mode_field,
	input  wire logic [15:0]   prog_data_in,
	output logic [15:0]        prog_data_out,
	output logic               prog_data_oe_n,
	input  wire logic          debug_flash_req,
	output logic               debug_flash_grant,
	output fbs_flash_op_t      flash_op,
	output logic               flash_full_erase,
	output logic               lock_error_irq,
	output logic [2:0]         nv_bits,
	output logic               boot_from_flash,
	output logic               rom_at_zero,
	output logic               second_bank_first,
	output logic               read_width_128,
	output logic               fast_prog_mode
);
	localparam int NW = $bits(fbs_pins_t);
	localparam logic [NW-1:0] PIN_IDLE = `FBS_PIN_IDLE;
	localparam logic [15:0] DEB_M1 = 16'(DEB_TICKS - 1);
	localparam logic [31:0] LOCK_MASK = LARGE_PART ? `FBS_LOCK_ALL : `FBS_LOCK_SML;

	logic [NW-1:0] pin_raw;
	logic [NW-1:0] s1, s2, s3, sq;
	fbs_pins_t     p;
	logic          slow_prev;
	logic          slow_tick;
	logic [15:0]   deb_cnt;
	logic          erase_act;
	logic          erase_go;
	logic [3:0]    cfg;
	logic          stat_err;
	logic [31:0]   locks;
	logic [2:0]    general_purpose_nv_bits;
	logic [2:0]    strap_dly;
	fbs_pp_st_t    pp_st;
	logic          pp_have;
	logic          wr_cmd;
	logic [7:0]    cmd_code;
	logic [10:0]   cmd_page;
	logic          cmd_ctl1;
	logic          cmd_pgop;
	logic          cmd_locked;
	logic          pp_fire;
	logic          pp_ok;
	logic          pp_pgop;
	logic          pp_locked;
	logic          lock_abort;

	// pad levels gathered in the bit order of the pin struct
	assign pin_raw = {prog_data_in, prog_mode_field, prog_output_enable_n,
		prog_command_strobe_n, pa_level, test_mode_pin, slow_clk_in, erase_pin_in};
	// three stages per pin; value moves only when stages two and three agree
	assign p = fbs_pins_t'(sq);
	genvar gi;
	generate
		for (gi = 0; gi < NW; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!resetn) begin
					s1[gi] <= PIN_IDLE[gi];
					s2[gi] <= PIN_IDLE[gi];
					s3[gi] <= PIN_IDLE[gi];
					sq[gi] <= PIN_IDLE[gi];
				end else begin
					s1[gi] <= pin_raw[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					if (s2[gi] == s3[gi]) begin
						sq[gi] <= s3[gi];
					end
				end
			end
		end
	endgenerate

	// slow clock edge, seen as a sampled level on the fast clock
	always_ff @(posedge clk) begin
		if (!resetn) begin
			slow_prev <= 1'b0;
		end else begin
			slow_prev <= p.slow;
		end
	end
	assign slow_tick = p.slow & ~slow_prev;

	// debounce: counts slow edges while high, any low level restarts it
	assign erase_act = p.erase & ~cfg[`FBS_CFG_GPIO];
	always_ff @(posedge clk) begin
		if (!resetn || !erase_act) begin
			deb_cnt <= 16'h0000;
		end else if (slow_tick && deb_cnt <= DEB_M1) begin
			deb_cnt <= deb_cnt + 16'h0001;
		end
	end
	// one pulse per held assertion, however long the pin stays high
	assign erase_go = erase_act & slow_tick & (deb_cnt == DEB_M1);

	// register port decode
	assign wr_cmd     = reg_wr && (reg_addr == `FBS_A_CMD);
	assign cmd_code   = reg_wdata[`FBS_CMD_CODE];
	assign cmd_page   = reg_wdata[`FBS_CMD_ARG];
	assign cmd_ctl1   = reg_wdata[`FBS_CMD_CTL];
	assign cmd_pgop   = (cmd_code == `FBS_C_PROG) || (cmd_code == `FBS_C_PERASE);
	assign cmd_locked = locks[cmd_page[`FBS_PG_RGN]];

	// parallel port: a command is taken once per strobe, only in fast mode
	assign pp_fire   = fast_prog_mode && (pp_st == PP_IDLE) && !p.strobe_n;
	assign pp_ok     = pp_fire && !general_purpose_nv_bits[`FBS_NV_SEC];
	assign pp_pgop   = (p.mode == `FBS_P_PROG) || (p.mode == `FBS_P_PERASE);
	assign pp_locked = locks[p.data[`FBS_PG_RGN]];
	assign lock_abort = (wr_cmd && cmd_pgop && cmd_locked)
		|| (pp_ok && pp_pgop && pp_locked);

	// configuration; pin defaults to its erase role after reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg <= 4'h0;
		end else if (reg_wr && reg_addr == `FBS_A_CFG) begin
			cfg <= reg_wdata[3:0];
		end
	end
	assign read_width_128 = cfg[`FBS_CFG_RW128];
	assign erase_pin_out  = cfg[`FBS_CFG_OUT];
	assign erase_pin_oe_n = ~(cfg[`FBS_CFG_GPIO] & cfg[`FBS_CFG_DRV]);

	// sticky abort flag; a new abort wins over the write-one clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stat_err <= 1'b0;
		end else if (lock_abort) begin
			stat_err <= 1'b1;
		end else if (reg_wr && reg_addr == `FBS_A_STAT && reg_wdata[0]) begin
			stat_err <= 1'b0;
		end
	end
	assign lock_error_irq = stat_err;

	// lock bits; small part has only the lower half
	always_ff @(posedge clk) begin
		if (!resetn) begin
			locks <= 32'h00000000;
		end else if (erase_go) begin
			locks <= 32'h00000000;
		end else if (wr_cmd && cmd_code == `FBS_C_SLOCK) begin
			locks[cmd_page[`FBS_PG_RGN]] <= LOCK_MASK[cmd_page[`FBS_PG_RGN]];
		end else if (wr_cmd && cmd_code == `FBS_C_CLOCK) begin
			locks[cmd_page[`FBS_PG_RGN]] <= 1'b0;
		end else if (pp_ok && p.mode == `FBS_P_LOCK) begin
			locks[p.data[`FBS_PG_RGN]] <= LOCK_MASK[p.data[`FBS_PG_RGN]];
		end else if (pp_ok && p.mode == `FBS_P_UNLOCK) begin
			locks[p.data[`FBS_PG_RGN]] <= 1'b0;
		end else if (pp_ok && p.mode == `FBS_P_PROTECT) begin
			// protect closes every region; security stays a controller 0 command
			locks <= LOCK_MASK;
		end
	end

	// three nv bits, controller 0 only; security never cleared by command
	always_ff @(posedge clk) begin
		if (!resetn) begin
			general_purpose_nv_bits <= 3'h0;
		end else if (erase_go) begin
			general_purpose_nv_bits <= 3'h0;
		end else if (wr_cmd && !cmd_ctl1 && cmd_code == `FBS_C_SNV
			&& cmd_page < 11'(`FBS_NV_NUM)) begin
			general_purpose_nv_bits[cmd_page[1:0]] <= 1'b1;
		end else if (wr_cmd && !cmd_ctl1 && cmd_code == `FBS_C_CNV
			&& cmd_page < 11'(`FBS_NV_NUM) && cmd_page != 11'h000) begin
			general_purpose_nv_bits[cmd_page[1:0]] <= 1'b0;
		end
	end
	assign nv_bits           = general_purpose_nv_bits;
	assign boot_from_flash   = general_purpose_nv_bits[`FBS_NV_BOOT];
	assign rom_at_zero       = ~general_purpose_nv_bits[`FBS_NV_BOOT];
	assign second_bank_first = general_purpose_nv_bits[`FBS_NV_SWAP];
	assign debug_flash_grant = debug_flash_req & ~general_purpose_nv_bits[`FBS_NV_SEC];

	// array requests; locked ops raise no go, though page and erase follow wr_cmd when both ports fire, and full erase ignores locks
	always_ff @(posedge clk) begin
		if (!resetn) begin
			flash_op         <= '0;
			flash_full_erase <= 1'b0;
		end else begin
			flash_op.go <= (wr_cmd && cmd_pgop && !cmd_locked)
				|| (pp_ok && pp_pgop && !pp_locked);
			flash_op.erase <= wr_cmd ? (cmd_code == `FBS_C_PERASE)
				: (p.mode == `FBS_P_PERASE);
			flash_op.page <= wr_cmd ? cmd_page : p.data[10:0];
			flash_full_erase <= erase_go || (pp_ok && p.mode == `FBS_P_FERASE);
		end
	end

	// strap capture after release; the synchroniser restarts from idle levels,
	// so the pad values reach p only at the fourth edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			strap_dly      <= 3'h0;
			fast_prog_mode <= 1'b0;
		end else if (strap_dly != `FBS_STRAP_DLY) begin
			strap_dly <= strap_dly + 3'h1;
			if (strap_dly == `FBS_STRAP_DLY - 3'h1) begin
				fast_prog_mode <= p.test && (p.pa == `FBS_STRAP_PA);
			end
		end
	end

	// parallel handshake: ready drops on take, rises when strobe releases
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pp_st         <= PP_IDLE;
			prog_ready    <= 1'b1;
			pp_have       <= 1'b0;
			prog_data_out <= 16'h0000;
		end else begin
			case (pp_st)
				PP_IDLE: begin
					if (pp_fire) begin
						pp_st      <= PP_HOLD;
						prog_ready <= 1'b0;
						// refused reads return nothing, valid stays high
						if (pp_ok && p.mode == `FBS_P_READ) begin
							pp_have       <= 1'b1;
							prog_data_out <= p.data[0] ? locks[31:16] : locks[15:0];
						end
					end
				end
				PP_HOLD: begin
					if (p.strobe_n) begin
						pp_st      <= PP_IDLE;
						prog_ready <= 1'b1;
						pp_have    <= 1'b0;
					end
				end
				default: begin
					pp_st <= PP_IDLE;
				end
			endcase
		end
	end
	// the programmer owns the bus until it pulls its enable low while read data is held
	assign prog_data_valid_n = ~(pp_have & ~p.oe_n);
	assign prog_data_oe_n    = ~(pp_have & ~p.oe_n);

	// read data stand for each cycle after one with reg_rd high, zero otherwise
	always_ff @(posedge clk) begin
		if (!resetn || !reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else begin
			case (reg_addr)
				`FBS_A_LOCK: reg_rdata <= locks;
				`FBS_A_NV:   reg_rdata <= {29'h00000000, general_purpose_nv_bits};
				`FBS_A_CFG:  reg_rdata <= {28'h0000000, cfg};
				`FBS_A_STAT: reg_rdata <= {31'h00000000, stat_err};
				`FBS_A_UID0: reg_rdata <= UID[31:0];
				`FBS_A_UID1: reg_rdata <= UID[63:32];
				`FBS_A_UID2: reg_rdata <= UID[95:64];
				`FBS_A_UID3: reg_rdata <= UID[127:96];
				`FBS_A_CAL:  reg_rdata <= CAL;
				default:     reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	erase_clears_all_a: assert property (
		erase_go |=> locks == 32'h00000000 && general_purpose_nv_bits == 3'h0 && flash_full_erase)
		else $error("erase left state");
	gpio_no_erase_a: assert property (
		cfg[`FBS_CFG_GPIO] |-> !erase_go)
		else $error("erase while pin is general output");
	debounce_count_a: assert property (
		erase_go |-> $past(erase_act) && deb_cnt == DEB_M1)
		else $error("erase before threshold");
	secure_debug_a: assert property (
		general_purpose_nv_bits[`FBS_NV_SEC] |-> !debug_flash_grant && !pp_ok)
		else $error("access while secured");
	locked_abort_a: assert property (
		wr_cmd && cmd_pgop && cmd_locked |=> !flash_op.go && lock_error_irq)
		else $error("locked op not aborted");
	set_lock_a: assert property (
		wr_cmd && cmd_code == `FBS_C_SLOCK && !erase_go
		&& LOCK_MASK[cmd_page[`FBS_PG_RGN]] |=> locks[$past(cmd_page[`FBS_PG_RGN])])
		else $error("lock not set");
	ctl1_nv_a: assert property (
		wr_cmd && cmd_ctl1 && !pp_fire && !erase_go |=> $stable(general_purpose_nv_bits))
		else $error("controller 1 changed nv bits");
	sec_sticky_a: assert property (
		general_purpose_nv_bits[`FBS_NV_SEC] && !erase_go |=> general_purpose_nv_bits[`FBS_NV_SEC])
		else $error("security cleared without erase");
	boot_rom_a: assert property (
		$past(erase_go) |-> rom_at_zero && !boot_from_flash)
		else $error("boot not from rom after erase");
	pin_default_a: assert property (
		$past(!resetn) |-> !cfg[`FBS_CFG_GPIO] && erase_pin_oe_n)
		else $error("erase pin not in erase role");
	// a new abort must show even when software clears the flag in that cycle
	abort_flag_a: assert property (
		lock_abort |=> lock_error_irq)
		else $error("abort flag lost");
	ready_drop_a: assert property (
		pp_fire |=> !prog_ready)
		else $error("ready kept high after take");
	protect_locks_a: assert property (
		pp_ok && p.mode == `FBS_P_PROTECT && !erase_go && !wr_cmd |=> locks == LOCK_MASK)
		else $error("protect left a region open");
	strap_entry_a: assert property (
		strap_dly == `FBS_STRAP_DLY - 3'h1
		|=> fast_prog_mode == $past(p.test && p.pa == `FBS_STRAP_PA))
		else $error("strap not captured");

	erase_seen_c: cover property (erase_go);
	read_done_c: cover property (pp_have && !prog_data_valid_n);
	abort_seen_c: cover property (lock_abort);
	fast_mode_c: cover property ($rose(fast_prog_mode));
endmodule // fbs_top
`default_nettype wire

// ===== hdl/fbs_defs.svh
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH
`define FBS_DEB_MS    200
`define FBS_SLOW_HZ   32768
`define FBS_DEB_TICKS ((`FBS_DEB_MS * `FBS_SLOW_HZ) / 1000)
`define FBS_A_CMD     8'h00
`define FBS_A_LOCK    8'h04
`define FBS_A_NV      8'h08
`define FBS_A_CFG     8'h0C
`define FBS_A_STAT    8'h10
`define FBS_A_UID0    8'h14
`define FBS_A_UID1    8'h18
`define FBS_A_UID2    8'h1C
`define FBS_A_UID3    8'h20
`define FBS_A_CAL     8'h24
`define FBS_CMD_CODE  7:0
`define FBS_CMD_ARG   18:8
`define FBS_CMD_CTL   24
`define FBS_PG_RGN    10:6
`define FBS_C_PROG    8'h01
`define FBS_C_PERASE  8'h02
`define FBS_C_SLOCK   8'h08
`define FBS_C_CLOCK   8'h09
`define FBS_C_SNV     8'h0B
`define FBS_C_CNV     8'h0C
`define FBS_P_READ    4'h1
`define FBS_P_PROG    4'h2
`define FBS_P_PERASE  4'h3
`define FBS_P_FERASE  4'h4
`define FBS_P_LOCK    4'h5
`define FBS_P_UNLOCK  4'h6
`define FBS_P_PROTECT 4'h7
`define FBS_CFG_RW128 0
`define FBS_CFG_GPIO  1
`define FBS_CFG_OUT   2
`define FBS_CFG_DRV   3
`define FBS_NV_SEC    0
`define FBS_NV_BOOT   1
`define FBS_NV_SWAP   2
`define FBS_STRAP_PA  4'h3
`define FBS_STRAP_DLY 3'h5
`define FBS_PIN_IDLE  29'h0000180
`define FBS_LOCK_ALL  32'hFFFFFFFF
`define FBS_LOCK_SML  32'h0000FFFF
`define FBS_NV_NUM    3
`endif

// ===== hdl/fbs_pkg.sv
`default_nettype none
package fbs_pkg;
	// pin levels as they arrive from the pads, one struct for the synchroniser
	typedef struct packed {
		logic [15:0] data;
		logic [3:0]  mode;
		logic        oe_n;
		logic        strobe_n;
		logic [3:0]  pa;
		logic        test;
		logic        slow;
		logic        erase;
	} fbs_pins_t;
	// request to the flash array
	typedef struct packed {
		logic        go;
		logic        erase;
		logic [10:0] page;
	} fbs_flash_op_t;
	typedef enum logic {PP_IDLE, PP_HOLD} fbs_pp_st_t;
endpackage
`default_nettype wire

// ===== tb/fbs_prog_model.sv
`default_nettype none
module fbs_prog_model (
	input  wire logic        clk,
	input  wire logic        prog_ready,
	input  wire logic        prog_data_valid_n,
	input  wire logic [15:0] prog_data_out,
	input  wire logic        prog_data_oe_n,
	output logic             test_mode_pin,
	output logic [3:0]       pa_level,
	output logic             prog_command_strobe_n,
	output logic             prog_output_enable_n,
	output logic [3:0]       prog_mode_field,
	output logic [15:0]      prog_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels from time zero, straps off
	initial begin
		test_mode_pin = 1'b0;
		pa_level = 4'h0;
		prog_command_strobe_n = 1'b1;
		prog_output_enable_n = 1'b1;
		prog_mode_field = 4'h0;
		prog_data_in = 16'h0000;
	end
	// straps must stay put across the reset release
	task automatic strap(input bit on);
		test_mode_pin <= on;
		pa_level <= on ? 4'h3 : 4'h0;
	endtask
	// one handshaked command; data released as inverse so stale values never pass
	task automatic run(input logic [3:0] m, input logic [15:0] d,
		output logic [15:0] q, output bit ok);
		int n;
		@(posedge clk);
		prog_mode_field <= m;
		prog_data_in <= d;
		prog_command_strobe_n <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prog_ready !== 1'b0 && n < 20);
		prog_output_enable_n <= 1'b0;
		ok = 0;
		for (n = 0; n < 10 && !ok; n++) begin
			@(posedge clk);
			ok = (prog_data_valid_n === 1'b0) && (prog_data_oe_n === 1'b0);
		end
		q = prog_data_out;
		prog_command_strobe_n <= 1'b1;
		prog_output_enable_n <= 1'b1;
		prog_data_in <= ~d;
		prog_mode_field <= ~m;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prog_ready !== 1'b1 && n < 20);
	endtask
endmodule // fbs_prog_model
`default_nettype wire

// ===== tb/fbs_top_tb.sv
`include "fbs_defs.svh"
`default_nettype none
module fbs_top_tb;
	import fbs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [127:0] UIDP = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
	localparam logic [31:0]  CALP = 32'h00005A5A;
	logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, ext_erase = 0, slow_clk_in = 0;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, exp_lock, exp_nv, got;
	logic erase_pin_in, erase_pin_out, erase_pin_oe_n, test_mode_pin, prog_command_strobe_n;
	logic [3:0] pa_level, prog_mode_field;
	logic prog_ready, prog_output_enable_n, prog_data_valid_n, prog_data_oe_n;
	logic debug_flash_req = 1;
	logic [15:0] prog_data_in, prog_data_out, q;
	logic debug_flash_grant, flash_full_erase, lock_error_irq, boot_from_flash, rom_at_zero;
	logic second_bank_first, read_width_128, fast_prog_mode;
	logic [2:0] nv_bits;
	fbs_flash_op_t flash_op, last_op;
	int err_count = 0, checks_done = 0, erase_seen = 0, cycles = 0, seed = 40, i;
	logic [4:0] r;
	logic [10:0] pg;
	bit ok;
	// pin has a pull-down; design drives it only with enable low
	assign erase_pin_in = !erase_pin_oe_n ? erase_pin_out : ext_erase;
	always #2 clk = ~clk;
	// slow clock toggling on clk falling edges, 8 clk per period
	always #16 slow_clk_in = ~slow_clk_in;
	fbs_top #(.DEB_TICKS(4)) dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .erase_pin_in, .erase_pin_out, .erase_pin_oe_n, .slow_clk_in,
		.test_mode_pin, .pa_level, .prog_command_strobe_n, .prog_ready,
		.prog_output_enable_n, .prog_data_valid_n, .prog_mode_field, .prog_data_in,
		.prog_data_out, .prog_data_oe_n, .debug_flash_req, .debug_flash_grant,
		.flash_op, .flash_full_erase, .lock_error_irq, .nv_bits, .boot_from_flash,
		.rom_at_zero, .second_bank_first, .read_width_128, .fast_prog_mode);
	fbs_prog_model pm (.clk, .prog_ready, .prog_data_valid_n, .prog_data_out,
		.prog_data_oe_n,
		.test_mode_pin, .pa_level, .prog_command_strobe_n, .prog_output_enable_n,
		.prog_mode_field, .prog_data_in);
	// erase pulses and hang guard
	always @(posedge clk) begin
		if (flash_full_erase === 1'b1)
			erase_seen++;
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
		#1 last_op = flash_op;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [10:0] a, input logic ctl = 0);
		wr(`FBS_A_CMD, {7'h0, ctl, 5'h0, a, c});
	endtask
	task automatic erase_hold(input int n);
		ext_erase <= 1;
		repeat (n) @(posedge clk);
		ext_erase <= 0;
		repeat (40) @(posedge clk);
	endtask
	task automatic do_reset(input bit fast);
		resetn <= 0;
		pm.strap(fast);
		repeat (12) @(posedge clk);
		resetn <= 1;
		repeat (5) @(posedge clk);
		// let the strap capture of the fifth edge settle before looking
		#1;
	endtask
	initial begin
		do_reset(0);
		exp_lock = 0;
		exp_nv = 0;
		rd(`FBS_A_LOCK, 0);
		rd(`FBS_A_NV, 0);
		for (i = 0; i < 4; i++)
			rd(`FBS_A_UID0 + 8'(4 * i), UIDP[32 * i +: 32]);
		rd(`FBS_A_CAL, CALP);
		rd(8'h3C, 0);
		chk(rom_at_zero, 1);
		chk(erase_pin_oe_n, 1);
		// random regions: lock, refused program, unlock, erase goes out, relock
		for (i = 0; i < 3; i++) begin
			r = 5'($random(seed));
			pg = {r, 6'($random(seed))};
			cmd(`FBS_C_SLOCK, pg);
			exp_lock = exp_lock | (32'h1 << r);
			rd(`FBS_A_LOCK, exp_lock);
			cmd(`FBS_C_PROG, pg);
			chk(last_op.go, 0);
			chk(lock_error_irq, 1);
			wr(`FBS_A_STAT, 1);
			chk(lock_error_irq, 0);
			cmd(`FBS_C_CLOCK, pg);
			cmd(`FBS_C_PERASE, pg);
			chk(last_op, {1'b1, 1'b1, pg});
			cmd(`FBS_C_SLOCK, pg);
		end
		// nv bits: other controller refused, index 3 does not exist
		cmd(`FBS_C_SNV, 1, 1);
		rd(`FBS_A_NV, 0);
		for (i = 1; i < 4; i++)
			cmd(`FBS_C_SNV, 11'(i));
		exp_nv = 6;
		rd(`FBS_A_NV, exp_nv);
		chk({boot_from_flash, rom_at_zero, second_bank_first}, 3'b101);
		cmd(`FBS_C_CNV, 2);
		chk(second_bank_first, 0);
		cmd(`FBS_C_SNV, 0);
		cmd(`FBS_C_CNV, 0);
		rd(`FBS_A_NV, 3);
		chk(debug_flash_grant, 0);
		wr(`FBS_A_CFG, 1);
		chk(read_width_128, 1);
		wr(`FBS_A_CFG, 0);
		chk(read_width_128, 0);
		// short high is ignored, long high erases once
		erase_hold(16);
		chk(erase_seen, 0);
		rd(`FBS_A_LOCK, exp_lock);
		erase_hold(80);
		chk(erase_seen, 1);
		rd(`FBS_A_LOCK, 0);
		rd(`FBS_A_NV, 0);
		chk(rom_at_zero, 1);
		rd(`FBS_A_UID3, UIDP[127:96]);
		rd(`FBS_A_CAL, CALP);
		// pin as general output driving high must not erase
		cmd(`FBS_C_SLOCK, 11'h040);
		wr(`FBS_A_CFG, 32'hE);
		chk({erase_pin_oe_n, erase_pin_out}, 2'b01);
		repeat (80) @(posedge clk);
		chk(erase_seen, 1);
		rd(`FBS_A_LOCK, 2);
		wr(`FBS_A_CFG, 0);
		// strap reset into fast programming, then every port command except program in turn
		do_reset(1);
		chk(fast_prog_mode, 1);
		r = 5'($random(seed)) & 5'hF;
		pg = {r, 6'h0};
		pm.run(`FBS_P_LOCK, {5'h0, pg}, q, ok);
		pm.run(`FBS_P_READ, 0, q, ok);
		chk({ok, q}, {1'b1, 16'h1 << r});
		rd(`FBS_A_LOCK, 32'h1 << r);
		pm.run(`FBS_P_UNLOCK, {5'h0, pg}, q, ok);
		rd(`FBS_A_LOCK, 0);
		pm.run(`FBS_P_PROTECT, 0, q, ok);
		rd(`FBS_A_LOCK, 32'hFFFFFFFF);
		chk(nv_bits, 0);
		pm.run(`FBS_P_PERASE, 16'h0040, q, ok);
		chk(lock_error_irq, 1);
		wr(`FBS_A_STAT, 1);
		pm.run(`FBS_P_FERASE, 0, q, ok);
		chk(erase_seen, 2);
		cmd(`FBS_C_SNV, 0);
		chk(nv_bits[0], 1);
		pm.run(`FBS_P_READ, 0, q, ok);
		chk(ok, 0);
		erase_hold(80);
		chk(nv_bits, 0);
		chk(erase_seen, 3);
		pm.run(`FBS_P_READ, 0, q, ok);
		chk({ok, q}, {1'b1, 16'h0000});
		report_and_stop();
	end
endmodule // fbs_top_tb
`default_nettype wire
